// ===== src/fault_recorder_pkg.sv
// constants, register map and carrier types of the fault history recorder
// assumes one 40 MHz system clock and a plain address/strobe register port
package fault_recorder_pkg;

   localparam int DATA_W  = 16;
   localparam int ADDR_W  = 16;
   localparam int DI_COUNT = 5;

   // register addresses are the parameter numbers, not byte offsets
   localparam logic [ADDR_W-1:0] ADDR_ALARM_TWO       = 16'h0309;
   localparam logic [ADDR_W-1:0] ADDR_ALARM_THREE     = 16'h0310;
   localparam logic [ADDR_W-1:0] ADDR_LATEST_FAULT    = 16'h0401;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_DAY       = 16'h0402;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_TIME      = 16'h0403;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_SPEED     = 16'h0404;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_FREQ      = 16'h0405;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_VOLTAGE   = 16'h0406;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_CURRENT   = 16'h0407;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_TORQUE    = 16'h0408;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS    = 16'h0409;
   localparam logic [ADDR_W-1:0] ADDR_SECOND_FAULT    = 16'h0412;
   localparam logic [ADDR_W-1:0] ADDR_THIRD_FAULT     = 16'h0413;
   localparam logic [ADDR_W-1:0] ADDR_FAULT_INPUTS    = 16'h0414;

   // alarm word two bit positions
   localparam int BIT_START_DELAY         = 11;
   localparam int BIT_SUCTION_LOW         = 13;
   localparam int BIT_DISCHARGE_HIGH      = 14;
   localparam int BIT_PIPE_FILL           = 15;
   // alarm word three bit positions
   localparam int BIT_SUCTION_CRITICAL    = 0;
   localparam int BIT_DISCHARGE_CRITICAL  = 1;

   localparam logic [DATA_W-1:0] RESET_VALUE   = 16'h0000;
   localparam logic [DATA_W-1:0] CLEAR_VALUE   = 16'h0000;
   localparam logic [DATA_W-1:0] NO_FAULT_CODE = 16'h0000;
   localparam logic [DATA_W-1:0] UNMAPPED_DATA = 16'h0000;

   // elapsed time base: 2 s ticks, 30 ticks a minute, 43200 a day
   localparam int CLK_PERIOD_NS  = 25;
   localparam int TICK_PERIOD_MS = 2000;
   localparam int TICK_CYCLES    = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [DATA_W-1:0] TICKS_PER_DAY = 16'hA8C0;
   localparam logic [DATA_W-1:0] TICK_ONE      = 16'h0001;

   typedef struct packed {
      logic pipe_fill;
      logic discharge_pressure_high_alarm;
      logic suction_pressure_low_alarm;
      logic start_delay;
   } alarm_two_event_type;

   typedef struct packed {
      logic discharge_pressure_critical_alarm;
      logic suction_pressure_critical_alarm;
   } alarm_three_event_type;

   typedef struct packed {
      logic [DATA_W-1:0]   speed;
      logic [DATA_W-1:0]   frequency;
      logic [DATA_W-1:0]   dc_voltage;
      logic [DATA_W-1:0]   current;
      logic [DATA_W-1:0]   torque;
      logic [DATA_W-1:0]   status;
      logic [DI_COUNT-1:0] inputs;
   } fault_snapshot_type;

   typedef struct packed {
      logic [DATA_W-1:0] day;
      logic [DATA_W-1:0] time_of_day;
   } time_stamp_type;

endpackage

// ===== src/elapsed_time_counter.sv
// elapsed time since power-on: whole days and 2 s ticks within the day
// assumes reset is applied at power-on; runs on the system clock only
`timescale 1ns/100ps
`default_nettype none

module elapsed_time_counter
   import fault_recorder_pkg::*;
#(
   parameter int TICK_LEN = fault_recorder_pkg::TICK_CYCLES
)
(
   input  wire logic                            i_sys_clk,
   input  wire logic                            i_rst_n,
   output fault_recorder_pkg::time_stamp_type   o_elapsed
);

   logic [31:0]    prescale;
   logic [31:0]    next_prescale;
   time_stamp_type elapsed;
   time_stamp_type next_elapsed;

   always_comb
   begin
      next_prescale = prescale + 32'h00000001;
      next_elapsed  = elapsed;
      if (prescale >= 32'(TICK_LEN - 1))
      begin
         next_prescale = 32'h00000000;
         // ticks exclude whole days already counted
         if (elapsed.time_of_day >= TICKS_PER_DAY - TICK_ONE)
         begin
            next_elapsed.time_of_day = RESET_VALUE;
            next_elapsed.day         = elapsed.day + TICK_ONE;
         end
         else
         begin
            next_elapsed.time_of_day = elapsed.time_of_day + TICK_ONE;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         prescale <= 32'h00000000;
         elapsed  <= '0;
      end
      else
      begin
         prescale <= next_prescale;
         elapsed  <= next_elapsed;
      end
   end

   assign o_elapsed = elapsed;

endmodule

`default_nettype wire

// ===== src/fault_history_alarm_recorder.sv
// alarm words two and three and the read-only fault history of a motor drive
// assumes a register master with one-cycle strobes and synchronous inputs
//
// Contract
// - word two: 11 start delay, 13 suction low, 14 discharge high, 15 fill
// - alarm word three is one 16-bit word read as a unit
// - writing zero to an alarm word clears all its bits, no per-bit clear; a set arriving in the clear cycle still leaves its bit set
// - word three: 0 suction critical, 1 discharge critical, others zero
// - latest fault register holds newest code; zero means empty history
// - first stamp: date while clock runs, else whole days since power-on
// - second stamp holds time of day, else elapsed time less whole days
// - elapsed time counts in 2 second ticks, 30 ticks per minute
// - speed latched on fault, one count per rpm
// - output frequency latched on fault, 0.1 Hz per count
// - DC-link voltage latched on fault, 0.1 V per count
// - motor current latched on fault, 0.1 A per count
// - torque latched on fault, 0.1 percent of nominal per count
// - drive status word latched on fault, read as hexadecimal
// - two older fault codes kept: second and third most recent
// - five digital inputs latched, input one in the top bit
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module fault_history_alarm_recorder
   import fault_recorder_pkg::*;
#(
   parameter int TICK_LEN = fault_recorder_pkg::TICK_CYCLES
)
(
   input  wire logic                                   i_sys_clk,
   input  wire logic                                   i_rst_n,
   input  wire logic [fault_recorder_pkg::ADDR_W-1:0]  i_addr,
   input  wire logic [fault_recorder_pkg::DATA_W-1:0]  i_wr_data,
   input  wire logic                                   i_wr_en,
   input  wire logic                                   i_rd_en,
   output logic      [fault_recorder_pkg::DATA_W-1:0]  o_rd_data,
   input  wire fault_recorder_pkg::alarm_two_event_type i_alarm_two_set,
   input  wire fault_recorder_pkg::alarm_three_event_type i_alarm_three_set,
   input  wire logic                                   i_fault_valid,
   input  wire logic [fault_recorder_pkg::DATA_W-1:0]  i_fault_code,
   input  wire fault_recorder_pkg::fault_snapshot_type i_fault_snapshot,
   input  wire logic                                   i_rtc_running,
   input  wire logic [fault_recorder_pkg::DATA_W-1:0]  i_rtc_date,
   input  wire logic [fault_recorder_pkg::DATA_W-1:0]  i_rtc_time,
   output logic      [fault_recorder_pkg::DATA_W-1:0]  o_alarm_two,
   output logic      [fault_recorder_pkg::DATA_W-1:0]  o_alarm_three,
   output logic                                        o_fault_present
);

   import fault_recorder_pkg::*;

   // ------------------------------------------------------------------
   // elapsed time base
   // ------------------------------------------------------------------

   time_stamp_type elapsed;

   elapsed_time_counter
   #(
      .TICK_LEN (TICK_LEN)
   )
   u_elapsed
   (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .o_elapsed (elapsed)
   );

   // ------------------------------------------------------------------
   // alarm words
   // ------------------------------------------------------------------

   logic [DATA_W-1:0] alarm_two;
   logic [DATA_W-1:0] next_alarm_two;
   logic [DATA_W-1:0] alarm_three;
   logic [DATA_W-1:0] next_alarm_three;
   logic              clear_alarm_two;
   logic              clear_alarm_three;

   assign clear_alarm_two   = i_wr_en && (i_addr == ADDR_ALARM_TWO)
                              && (i_wr_data == CLEAR_VALUE);
   assign clear_alarm_three = i_wr_en && (i_addr == ADDR_ALARM_THREE)
                              && (i_wr_data == CLEAR_VALUE);

   always_comb
   begin
      next_alarm_two   = alarm_two;
      next_alarm_three = alarm_three;
      if (clear_alarm_two)
      begin
         next_alarm_two = CLEAR_VALUE;
      end
      if (clear_alarm_three)
      begin
         next_alarm_three = CLEAR_VALUE;
      end
      // sets come after the clear so an event in the clear cycle survives
      // alarm word two bits, then alarm word three bits
      if (i_alarm_two_set.start_delay)
      begin
         next_alarm_two[BIT_START_DELAY] = 1'h1;
      end
      if (i_alarm_two_set.suction_pressure_low_alarm)
      begin
         next_alarm_two[BIT_SUCTION_LOW] = 1'h1;
      end
      if (i_alarm_two_set.discharge_pressure_high_alarm)
      begin
         next_alarm_two[BIT_DISCHARGE_HIGH] = 1'h1;
      end
      if (i_alarm_two_set.pipe_fill)
      begin
         next_alarm_two[BIT_PIPE_FILL] = 1'h1;
      end
      if (i_alarm_three_set.suction_pressure_critical_alarm)
      begin
         next_alarm_three[BIT_SUCTION_CRITICAL] = 1'h1;
      end
      if (i_alarm_three_set.discharge_pressure_critical_alarm)
      begin
         next_alarm_three[BIT_DISCHARGE_CRITICAL] = 1'h1;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         alarm_two   <= RESET_VALUE;
         alarm_three <= RESET_VALUE;
      end
      else
      begin
         alarm_two   <= next_alarm_two;
         alarm_three <= next_alarm_three;
      end
   end

   assign o_alarm_two   = alarm_two;
   assign o_alarm_three = alarm_three;

   // ------------------------------------------------------------------
   // fault history
   // ------------------------------------------------------------------

   logic [DATA_W-1:0]  latest_fault_code;
   logic [DATA_W-1:0]  next_latest_fault_code;
   logic [DATA_W-1:0]  second_latest_fault_code;
   logic [DATA_W-1:0]  next_second_latest_fault_code;
   logic [DATA_W-1:0]  third_latest_fault_code;
   logic [DATA_W-1:0]  next_third_latest_fault_code;
   time_stamp_type     fault_stamp;
   time_stamp_type     next_fault_stamp;
   fault_snapshot_type fault_snapshot;
   fault_snapshot_type next_fault_snapshot;
   logic               fault_accept;

   // a zero code would read as an empty history, so it is not recorded
   assign fault_accept = i_fault_valid && (i_fault_code != NO_FAULT_CODE);

   always_comb
   begin
      next_latest_fault_code        = latest_fault_code;
      next_second_latest_fault_code = second_latest_fault_code;
      next_third_latest_fault_code  = third_latest_fault_code;
      next_fault_stamp              = fault_stamp;
      next_fault_snapshot           = fault_snapshot;
      if (fault_accept)
      begin
         next_third_latest_fault_code  = second_latest_fault_code;
         next_second_latest_fault_code = latest_fault_code;
         next_latest_fault_code        = i_fault_code;
         if (i_rtc_running)
         begin
            next_fault_stamp.day         = i_rtc_date;
            next_fault_stamp.time_of_day = i_rtc_time;
         end
         else
         begin
            next_fault_stamp.day         = elapsed.day;
            next_fault_stamp.time_of_day = elapsed.time_of_day;
         end
         next_fault_snapshot.speed      = i_fault_snapshot.speed;
         next_fault_snapshot.frequency  = i_fault_snapshot.frequency;
         next_fault_snapshot.dc_voltage = i_fault_snapshot.dc_voltage;
         next_fault_snapshot.current    = i_fault_snapshot.current;
         next_fault_snapshot.torque     = i_fault_snapshot.torque;
         next_fault_snapshot.status     = i_fault_snapshot.status;
         next_fault_snapshot.inputs     = i_fault_snapshot.inputs;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         latest_fault_code        <= NO_FAULT_CODE;
         second_latest_fault_code <= NO_FAULT_CODE;
         third_latest_fault_code  <= NO_FAULT_CODE;
         fault_stamp              <= '0;
         fault_snapshot           <= '0;
      end
      else
      begin
         latest_fault_code        <= next_latest_fault_code;
         second_latest_fault_code <= next_second_latest_fault_code;
         third_latest_fault_code  <= next_third_latest_fault_code;
         fault_stamp              <= next_fault_stamp;
         fault_snapshot           <= next_fault_snapshot;
      end
   end

   assign o_fault_present = (latest_fault_code != NO_FAULT_CODE);

   // ------------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------------

   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] next_rd_data;
   logic [DATA_W-1:0] inputs_word;

   // input one sits in the top bit of the five
   assign inputs_word = {{(DATA_W-DI_COUNT){1'h0}}, fault_snapshot.inputs};

   // reads only; history has no write path
   always_comb
   begin
      next_rd_data = UNMAPPED_DATA;
      if (i_rd_en)
      begin
         unique case (i_addr)
            ADDR_ALARM_TWO:     next_rd_data = alarm_two;
            ADDR_ALARM_THREE:   next_rd_data = alarm_three;
            ADDR_LATEST_FAULT:  next_rd_data = latest_fault_code;
            ADDR_FAULT_DAY:     next_rd_data = fault_stamp.day;
            ADDR_FAULT_TIME:    next_rd_data = fault_stamp.time_of_day;
            ADDR_FAULT_SPEED:   next_rd_data = fault_snapshot.speed;
            ADDR_FAULT_FREQ:    next_rd_data = fault_snapshot.frequency;
            ADDR_FAULT_VOLTAGE: next_rd_data = fault_snapshot.dc_voltage;
            ADDR_FAULT_CURRENT: next_rd_data = fault_snapshot.current;
            ADDR_FAULT_TORQUE:  next_rd_data = fault_snapshot.torque;
            ADDR_FAULT_STATUS:  next_rd_data = fault_snapshot.status;
            ADDR_SECOND_FAULT:  next_rd_data = second_latest_fault_code;
            ADDR_THIRD_FAULT:   next_rd_data = third_latest_fault_code;
            ADDR_FAULT_INPUTS:  next_rd_data = inputs_word;
            default:            next_rd_data = UNMAPPED_DATA;
         endcase
      end
   end

   // data outside the answer cycle is zero so a stale value is never seen
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rst_n)
      begin
         rd_data <= RESET_VALUE;
      end
      else
      begin
         rd_data <= next_rd_data;
      end
   end

   assign o_rd_data = rd_data;

endmodule

`default_nettype wire

// ===== sim/fault_recorder_asserts.sv
// port assertions for the fault history recorder
// assumes binding into the recorder, one clock, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module fault_recorder_asserts
   import fault_recorder_pkg::*;
#(
   parameter int TICK_LEN = 4
)
(
   input wire logic                                  i_sys_clk,
   input wire logic                                  i_rst_n,
   input wire logic [15:0]                           i_addr,
   input wire logic [15:0]                           i_wr_data,
   input wire logic                                  i_wr_en,
   input wire logic                                  i_rd_en,
   input wire logic [15:0]                           o_rd_data,
   input wire fault_recorder_pkg::alarm_two_event_type   i_alarm_two_set,
   input wire fault_recorder_pkg::alarm_three_event_type i_alarm_three_set,
   input wire logic                                  i_fault_valid,
   input wire logic [15:0]                           i_fault_code,
   input wire fault_recorder_pkg::fault_snapshot_type    i_fault_snapshot,
   input wire logic [15:0]                           o_alarm_two,
   input wire logic [15:0]                           o_alarm_three,
   input wire logic                                  o_fault_present
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n);
   wire clr3 = i_wr_en && i_addr == ADDR_ALARM_THREE && i_wr_data == 16'h0000;
   sequence s_cap;
      i_fault_valid && i_fault_code != 16'h0000;
   endsequence
   sequence s_rd(a);
      i_rd_en && i_addr == a && !i_fault_valid;
   endsequence
   chk_two_bits: assert property (
      i_alarm_two_set == 4'hF
      |=> o_alarm_two[15:13] == 3'h7 && o_alarm_two[11])
      else $error("alarm two bits not set");
   chk_two_spare: assert property (
      (o_alarm_two & 16'h17FF) == 16'h0000)
      else $error("alarm two spare bit set");
   chk_three_spare: assert property (
      o_alarm_three[15:2] == 14'h0000)
      else $error("alarm three spare bit set");
   chk_three_set: assert property (
      i_alarm_three_set.suction_pressure_critical_alarm |=> o_alarm_three[0])
      else $error("alarm three bit 0 not set");
   chk_zero_clear: assert property (
      clr3 && i_alarm_three_set == 2'h0 |=> o_alarm_three == 16'h0000)
      else $error("zero write did not clear");
   chk_three_hold: assert property (
      o_alarm_three[1] && !clr3 |=> o_alarm_three[1])
      else $error("alarm three bit lost");
   chk_fault_flag: assert property (
      s_cap |=> o_fault_present)
      else $error("fault present not raised");
   chk_latest_read: assert property (
      s_cap ##1 !i_fault_valid ##1 s_rd(ADDR_LATEST_FAULT)
      |=> o_rd_data == $past(i_fault_code, 3))
      else $error("latest code wrong");
   chk_speed_read: assert property (
      s_cap ##1 !i_fault_valid ##1 s_rd(ADDR_FAULT_SPEED)
      |=> o_rd_data == $past(i_fault_snapshot.speed, 3))
      else $error("speed snapshot wrong");
   chk_idle_zero: assert property (
      !i_rd_en |=> o_rd_data == 16'h0000)
      else $error("read data not zero outside answer cycle");
endmodule
bind fault_history_alarm_recorder fault_recorder_asserts
   #(.TICK_LEN(TICK_LEN)) u_chk (.*);
`default_nettype wire

// ===== sim/register_host_model.sv
// panel or fieldbus master reading and writing recorder registers
// assumes one-cycle strobes and read data in the following cycle
`timescale 1ns/100ps
`default_nettype none
module register_host_model
(
   input  wire logic        i_sys_clk,
   input  wire logic [15:0] i_rd_data,
   output logic      [15:0] o_addr,
   output logic      [15:0] o_wr_data,
   output logic             o_wr_en,
   output logic             o_rd_en
);
   initial
   begin
      o_addr = 16'h0000;
      o_wr_data = 16'h0000;
      o_wr_en = 1'h0;
      o_rd_en = 1'h0;
   end
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_wr_data <= d;
      o_wr_en <= 1'h1;
      @(posedge i_sys_clk);
      o_wr_en <= 1'h0;
      // idle lines flip so a stale value never looks valid
      o_addr <= ~a;
      o_wr_data <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge i_sys_clk);
      o_addr <= a;
      o_rd_en <= 1'h1;
      @(posedge i_sys_clk);
      o_rd_en <= 1'h0;
      o_addr <= ~a;
      #1 d = i_rd_data;
   endtask
endmodule
`default_nettype wire

// ===== sim/test_fault_history_alarm_recorder.sv
// self-checking bench for the fault history recorder
// assumes the host model drives the register port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
      end \
   end
module test_fault_history_alarm_recorder;
   import fault_recorder_pkg::*;
   localparam logic [15:0] SNAP_ADDR [6] = '{ADDR_FAULT_SPEED,
      ADDR_FAULT_FREQ, ADDR_FAULT_VOLTAGE, ADDR_FAULT_CURRENT,
      ADDR_FAULT_TORQUE, ADDR_FAULT_STATUS};
   logic                  sys_clk = 1'h0;
   logic                  rst_n = 1'h0;
   logic [15:0]           addr, wr_data, rd_data, alarm_two, alarm_three;
   logic                  wr_en, rd_en, fault_present;
   logic                  fault_valid = 1'h0;
   logic                  rtc_running = 1'h0;
   logic [15:0]           fault_code = 16'h0000;
   logic [15:0]           rtc_date = 16'h0000;
   logic [15:0]           rtc_time = 16'h0000;
   logic [15:0]           t1, d;
   alarm_two_event_type   two_set = 4'h0;
   alarm_three_event_type three_set = 2'h0;
   fault_snapshot_type    snap = '0;
   int                    error_cnt = 0;
   int                    n_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   fault_history_alarm_recorder #(.TICK_LEN(4)) u_dut (
      .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_addr(addr),
      .i_wr_data(wr_data), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .o_rd_data(rd_data), .i_alarm_two_set(two_set),
      .i_alarm_three_set(three_set), .i_fault_valid(fault_valid),
      .i_fault_code(fault_code), .i_fault_snapshot(snap),
      .i_rtc_running(rtc_running), .i_rtc_date(rtc_date),
      .i_rtc_time(rtc_time), .o_alarm_two(alarm_two),
      .o_alarm_three(alarm_three), .o_fault_present(fault_present));
   register_host_model u_host (
      .i_sys_clk(sys_clk), .i_rd_data(rd_data), .o_addr(addr),
      .o_wr_data(wr_data), .o_wr_en(wr_en), .o_rd_en(rd_en));
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // snapshot members differ so a swapped register shows up
   task automatic fault(input logic [15:0] code, input logic [15:0] b);
      @(posedge sys_clk);
      fault_valid <= 1'h1;
      fault_code <= code;
      snap <= {b, b ^ 16'h1111, b ^ 16'h2222, b ^ 16'h3333,
               b ^ 16'h4444, b ^ 16'h5555, 5'h10};
      @(posedge sys_clk);
      fault_valid <= 1'h0;
   endtask
   task automatic t_reset();
      u_host.rd(ADDR_LATEST_FAULT, d);
      `CHK("latest", 16'h0000, d)
      `CHK("present", 1'h0, fault_present)
      for (int i = 0; i < 6; i++)
      begin
         u_host.rd(SNAP_ADDR[i], d);
         `CHK("empty snapshot", 16'h0000, d)
      end
      $display("test reset done");
   endtask
   task automatic t_alarms();
      @(posedge sys_clk);
      two_set <= 4'hF;
      three_set <= 2'h3;
      @(posedge sys_clk);
      two_set <= 4'h0;
      three_set <= 2'h0;
      #1;
      `CHK("alarm two", 16'hE800, alarm_two)
      `CHK("alarm three", 16'h0003, alarm_three)
      u_host.rd(ADDR_ALARM_THREE, d);
      `CHK("word three", 16'h0003, d)
      u_host.wr(ADDR_ALARM_TWO, 16'h0800);
      u_host.wr(ADDR_ALARM_THREE, 16'h0001);
      u_host.rd(ADDR_ALARM_TWO, d);
      `CHK("two kept", 16'hE800, d)
      `CHK("three kept", 16'h0003, alarm_three)
      u_host.wr(ADDR_ALARM_TWO, 16'h0000);
      u_host.wr(ADDR_ALARM_THREE, 16'h0000);
      u_host.rd(ADDR_ALARM_TWO, d);
      `CHK("two cleared", 16'h0000, d)
      `CHK("three cleared", 16'h0000, alarm_three)
      // a set in the clear cycle must survive the clear
      @(posedge sys_clk);
      three_set <= 2'h1;
      u_host.wr(ADDR_ALARM_THREE, 16'h0000);
      three_set <= 2'h0;
      #1;
      `CHK("set beats clear", 16'h0001, alarm_three)
      $display("test alarms done");
   endtask
   task automatic t_faults();
      fault(16'h0011, 16'h0100);
      fault(16'h0022, 16'h0200);
      fault(16'h0033, 16'h0300);
      u_host.rd(ADDR_LATEST_FAULT, d);
      `CHK("latest", 16'h0033, d)
      `CHK("present", 1'h1, fault_present)
      u_host.rd(ADDR_SECOND_FAULT, d);
      `CHK("second", 16'h0022, d)
      u_host.rd(ADDR_THIRD_FAULT, d);
      `CHK("third", 16'h0011, d)
      for (int i = 0; i < 6; i++)
      begin
         u_host.rd(SNAP_ADDR[i], d);
         `CHK("snapshot", 16'h0300 ^ (16'h1111 * i), d)
      end
      u_host.rd(ADDR_FAULT_INPUTS, d);
      `CHK("inputs", 16'h0010, d)
      fault(16'h0000, 16'h0900);
      u_host.wr(ADDR_LATEST_FAULT, 16'hFFFF);
      u_host.wr(16'h0500, 16'hFFFF);
      u_host.rd(ADDR_LATEST_FAULT, d);
      `CHK("latest kept", 16'h0033, d)
      u_host.rd(ADDR_FAULT_SPEED, d);
      `CHK("speed kept", 16'h0300, d)
      u_host.rd(16'h0500, d);
      `CHK("unmapped", 16'h0000, d)
      $display("test faults done");
   endtask
   task automatic t_stamp();
      @(posedge sys_clk);
      rtc_running <= 1'h1;
      rtc_date <= 16'h2B3C;
      rtc_time <= 16'h0C1D;
      fault(16'h0044, 16'h0400);
      u_host.rd(ADDR_FAULT_SPEED, d);
      `CHK("speed", 16'h0400, d)
      u_host.rd(ADDR_FAULT_DAY, d);
      `CHK("date", 16'h2B3C, d)
      u_host.rd(ADDR_FAULT_TIME, d);
      `CHK("clock time", 16'h0C1D, d)
      @(posedge sys_clk);
      rtc_running <= 1'h0;
      fault(16'h0055, 16'h0500);
      u_host.rd(ADDR_FAULT_TIME, t1);
      // captures 120 cycles apart, that is 30 ticks of 4 cycles
      repeat (116) @(posedge sys_clk);
      fault(16'h0066, 16'h0600);
      u_host.rd(ADDR_FAULT_TIME, d);
      `CHK("tick step", t1 + 16'h001E, d)
      u_host.rd(ADDR_FAULT_DAY, d);
      `CHK("day count", 16'h0000, d)
      $display("test stamps done");
   endtask
   initial
   begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'h1;
      t_reset();
      t_alarms();
      t_faults();
      t_stamp();
      close_out();
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      $display("ERROR run limit expected 0 seen 1");
      close_out();
   end
endmodule
`default_nettype wire
